// ===== verilog/irs_regs.svh
// Register offsets, field positions and reset values of the interrupt and reset status block
`ifndef IRS_REGS_SVH
`define IRS_REGS_SVH
`define IRS_WDC_OFFSET 8'h0e
`define IRS_STAT_OFFSET 8'h0f
`define IRS_MASK_OFFSET 8'h0f
`define IRS_BIT_TIMER 0
`define IRS_BIT_PORT 1
`define IRS_BIT_EXT 2
`define IRS_WDC_RUN_BIT 7
`define IRS_WDC_EXTSEL_BIT 6
`define IRS_WDC_ROPT_BIT 4
`define IRS_WDC_RESET 8'h80
`define IRS_IRQ_RESET 3'h0
`define IRS_VEC_IRQ 11'h008
`define IRS_VEC_TRAP 11'h001
`endif

// ===== verilog/irs_pkg.sv
// Types shared by the interrupt and reset status block
`default_nettype none
package irs_pkg;
	// Instruction strobes issued by the core, one-cycle pulses
	typedef struct packed {
		logic global_irq_on_op;
		logic global_irq_off_op;
		logic irq_return_op;
		logic sleep_op;
		logic watchdog_clear_op;
		logic trap_op;
	} irs_ops_s;
	// Register access from the core
	typedef struct packed {
		logic wr_data_reg;
		logic wr_ctl_reg;
		logic [7:0] addr;
		logic [7:0] wdata;
	} irs_acc_s;
	// Run state of the core
	typedef enum logic [0:0] {
		IRS_RUN = 1'b0,
		IRS_SLEEP = 1'b1
	} irs_mode_e;
endpackage
`default_nettype wire

// ===== verilog/irs_core.sv
// Interrupt flags, masks, vectoring and time-out/power-down status
// Notes on behaviour
// RULE_01 - Three falling-edge sources: timer, port, external; the code flags the port on any change
// RULE_02 - Software reads port before enabling change interrupt
// RULE_03 - Input pins flag changes; outputs, external pin excluded
// RULE_04 - Port change wakes; vectors only if global on
// RULE_05 - Status flags: timer bit0, port bit1, external bit2
// RULE_06 - Mask register uses the same bit positions
// RULE_07 - Enable and disable instructions drive global enable
// RULE_08 - Enabled interrupt with global on vectors 008H
// RULE_09 - Handler clears flag before return or re-enable
// RULE_10 - Timer, external flags set regardless of masks
// RULE_11 - Requests are flags ANDed with masks
// RULE_12 - Return instruction sets global enable
// RULE_13 - Enabled trap instruction vectors to 001H
// RULE_14 - Reset on power-on, reset pin, watchdog
// RULE_15 - Pin reset: keep flags running; sleep gives 1,0
// RULE_16 - Watchdog: clear time-out; from sleep both zero
// RULE_17 - Power-on sets both; pin wake gives 1,0
// RULE_18 - Clear sets both; sleep 1,0; time-out clears T
// RULE_19 - Resets clear status flags and mask bits
// RULE_20 - Reset sets watchdog enable, clears bits 4,6
// RULE_21 - Vector needs masked request; vectoring clears global
`timescale 1ns/10ps
`default_nettype none
`include "irs_regs.svh"
module irs_core #(
	parameter int PORT_W = 8
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic power_on, // Power-on reset pulse
	input wire logic rst_pin_n, // Active-low reset pin, synchronous
	input wire logic wdt_timeout, // Watchdog time-out pulse
	input wire logic timer_counter_ovf, // Timer overflow level
	input wire logic ext_pin, // External interrupt pin level (port6_bit0)
	input wire logic [PORT_W-1:0] port_in, // Change-detect port levels
	input wire logic [PORT_W-1:0] port_is_out, // High where the pin is an output
	input wire logic port_read, // Core reads the port
	input wire irs_pkg::irs_ops_s ops,
	input wire irs_pkg::irs_acc_s acc,
	output logic [7:0] stat_rd, // Status register read value
	output logic [7:0] mask_rd, // Mask register read value
	output logic [7:0] wdc_rd, // Watchdog control read value
	output logic time_out_flag,
	output logic power_down_flag,
	output logic global_irq_en,
	output logic sleeping,
	output logic reset_out, // Core held in reset while the reset pin is low
	output logic wake, // Resume pulse after pin-change wake
	output logic vec_take, // Fetch redirect pulse
	output logic [10:0] vec_addr
);
	// The snapshot and status paths are one byte wide, so wider ports are refused
	if (PORT_W < 1 || PORT_W > 8) begin : g_bad_width
		$error("PORT_W must be 1..8");
	end

	// Registered state
	logic [2:0] flag_q, flag_d;
	logic [2:0] mask_q, mask_d;
	logic [7:0] wdc_q, wdc_d;
	logic t_q, t_d, p_q, p_d, gie_q, gie_d;
	irs_pkg::irs_mode_e mode_q, mode_d;
	logic [PORT_W-1:0] snap_q, snap_d; // Port levels seen at last read
	logic tmr_q, ext_q, pin_q; // Previous levels for edge detection
	logic rst_q, rst_d, wake_q, wake_d, vt_q, vt_d;
	logic [10:0] va_q, va_d;

	// Write decode; status and mask share an offset, so the space strobe decides
	function automatic logic reg_hit(input logic strobe, input logic [7:0] addr,
			input logic [7:0] offs);
		reg_hit = strobe && (addr == offs);
	endfunction

	// Pins that take part in change detection
	wire logic [PORT_W-1:0] watch;
	logic port_chg, tmr_fall, ext_fall, pin_rise, any_rst, irq_any;
	logic ext_sel;
	always_comb begin
		ext_sel = wdc_q[`IRS_WDC_EXTSEL_BIT];
		port_chg = |((port_in ^ snap_q) & watch); // RULE_03
		tmr_fall = tmr_q & ~timer_counter_ovf; // RULE_01
		ext_fall = ext_q & ~ext_pin & ext_sel; // RULE_01
		pin_rise = ~pin_q & rst_pin_n; // RULE_14
		any_rst = power_on | pin_rise | wdt_timeout; // RULE_14
		irq_any = |(flag_q & mask_q); // RULE_11
	end

	// Change-detect mask per pin; bit 0 drops out while it serves as the external input
	for (genvar gi = 0; gi < PORT_W; gi++) begin : g_watch
		if (gi == 0) begin : g_shared
			assign watch[gi] = ~port_is_out[gi] & ~wdc_q[`IRS_WDC_EXTSEL_BIT]; // RULE_03
		end else begin : g_plain
			assign watch[gi] = ~port_is_out[gi]; // RULE_03
		end
	end

	// Next-state computation for all control state
	always_comb begin
		flag_d = flag_q;
		mask_d = mask_q;
		wdc_d = wdc_q;
		t_d = t_q;
		p_d = p_q;
		gie_d = gie_q;
		mode_d = mode_q;
		snap_d = snap_q;
		rst_d = ~rst_pin_n;
		wake_d = 1'b0;
		vt_d = 1'b0;
		va_d = va_q;
		// Register writes; hardware sets below win over software clears
		if (reg_hit(acc.wr_data_reg, acc.addr, `IRS_STAT_OFFSET))
			flag_d = acc.wdata[2:0]; // RULE_05
		if (reg_hit(acc.wr_ctl_reg, acc.addr, `IRS_MASK_OFFSET))
			mask_d = acc.wdata[2:0]; // RULE_06
		if (reg_hit(acc.wr_ctl_reg, acc.addr, `IRS_WDC_OFFSET))
			wdc_d = acc.wdata;
		if (port_read)
			snap_d = port_in; // RULE_02
		if (tmr_fall)
			flag_d[`IRS_BIT_TIMER] = 1'b1; // RULE_10
		if (ext_fall)
			flag_d[`IRS_BIT_EXT] = 1'b1; // RULE_10
		// Port flag only when its mask is on, unlike the other two
		if (port_chg && mask_q[`IRS_BIT_PORT])
			flag_d[`IRS_BIT_PORT] = 1'b1; // RULE_10
		// Instruction effects
		if (ops.global_irq_on_op || ops.irq_return_op)
			gie_d = 1'b1; // RULE_07 RULE_12
		if (ops.global_irq_off_op)
			gie_d = 1'b0; // RULE_07
		if (ops.watchdog_clear_op) begin
			t_d = 1'b1; // RULE_18
			p_d = 1'b1;
		end
		// Sleep entry takes precedence over a same-cycle trap or vector
		case (mode_q)
			irs_pkg::IRS_RUN: begin
				if (ops.sleep_op) begin
					t_d = 1'b1; // RULE_18
					p_d = 1'b0;
					mode_d = irs_pkg::IRS_SLEEP;
				end else if (ops.trap_op && gie_q) begin
					vt_d = 1'b1; // RULE_13
					va_d = `IRS_VEC_TRAP;
					gie_d = 1'b0;
				end else if (irq_any && gie_q && !vt_q) begin
					vt_d = 1'b1; // RULE_08 RULE_21
					va_d = `IRS_VEC_IRQ;
					gie_d = 1'b0; // RULE_21
				end
			end
			irs_pkg::IRS_SLEEP: begin
				if (port_chg && mask_q[`IRS_BIT_PORT]) begin
					mode_d = irs_pkg::IRS_RUN; // RULE_04
					t_d = 1'b1; // RULE_17
					p_d = 1'b0;
					wake_d = 1'b1;
					if (gie_q) begin
						vt_d = 1'b1; // RULE_04
						va_d = `IRS_VEC_IRQ;
						gie_d = 1'b0;
					end
				end
			end
			default: mode_d = irs_pkg::IRS_RUN;
		endcase
		// Reset sources override everything except the port snapshot, the reset output and the vector address
		// Pin and watchdog resets tell sleep from run only through these two flags
		if (any_rst) begin
			flag_d = `IRS_IRQ_RESET; // RULE_19
			mask_d = `IRS_IRQ_RESET; // RULE_19
			wdc_d = `IRS_WDC_RESET; // RULE_20
			gie_d = 1'b0;
			mode_d = irs_pkg::IRS_RUN;
			vt_d = 1'b0;
			wake_d = 1'b0;
			if (power_on) begin
				t_d = 1'b1; // RULE_17
				p_d = 1'b1;
			end else if (wdt_timeout) begin
				t_d = 1'b0; // RULE_16 RULE_18
				p_d = (mode_q == irs_pkg::IRS_SLEEP) ? 1'b0 : p_q; // RULE_16
			end else if (mode_q == irs_pkg::IRS_SLEEP) begin
				t_d = 1'b1; // RULE_15
				p_d = 1'b0;
			end else begin
				t_d = t_q; // RULE_15
				p_d = p_q;
			end
		end
	end

	// Edge detectors reset to levels that cannot fake an edge after reset
	// Registers; clock enable freezes everything
	always_ff @(posedge clk) begin
		if (srst) begin
			flag_q <= `IRS_IRQ_RESET;
			mask_q <= `IRS_IRQ_RESET;
			wdc_q <= `IRS_WDC_RESET;
			t_q <= 1'b1;
			p_q <= 1'b1;
			gie_q <= 1'b0;
			mode_q <= irs_pkg::IRS_RUN;
			snap_q <= '0;
			tmr_q <= 1'b0;
			ext_q <= 1'b0;
			pin_q <= 1'b1;
			rst_q <= 1'b0;
			wake_q <= 1'b0;
			vt_q <= 1'b0;
			va_q <= 11'h000;
		end else if (ce) begin
			flag_q <= flag_d;
			mask_q <= mask_d;
			wdc_q <= wdc_d;
			t_q <= t_d;
			p_q <= p_d;
			gie_q <= gie_d;
			mode_q <= mode_d;
			snap_q <= snap_d;
			tmr_q <= timer_counter_ovf;
			ext_q <= ext_pin;
			pin_q <= rst_pin_n;
			rst_q <= rst_d;
			wake_q <= wake_d;
			vt_q <= vt_d;
			va_q <= va_d;
		end
	end

	// Pulses last one cycle; levels hold until the next change
	// Outputs straight from flip-flops
	assign stat_rd = {5'h00, flag_q};
	assign mask_rd = {5'h00, mask_q};
	assign wdc_rd = wdc_q;
	assign time_out_flag = t_q;
	assign power_down_flag = p_q;
	assign global_irq_en = gie_q;
	assign sleeping = (mode_q == irs_pkg::IRS_SLEEP);
	assign reset_out = rst_q;
	assign wake = wake_q;
	assign vec_take = vt_q;
	assign vec_addr = va_q;

	// Checks
	timer_flag_set_a: assert property (@(posedge clk) disable iff (srst) // RULE_10
		ce && tmr_fall && !any_rst |=> flag_q[`IRS_BIT_TIMER])
		else $error("timer flag not set");
	vector_irq_a: assert property (@(posedge clk) disable iff (srst) // RULE_08
		vec_take && va_q == `IRS_VEC_IRQ |-> $past(gie_q))
		else $error("vector without global enable");
	vector_clears_gie_a: assert property (@(posedge clk) disable iff (srst) // RULE_21
		ce && vt_d |=> !gie_q)
		else $error("global enable kept on vectoring");
	enable_op_a: assert property (@(posedge clk) disable iff (srst) // RULE_07
		ce && ops.global_irq_on_op && !any_rst && !ops.global_irq_off_op && !vt_d |=> gie_q)
		else $error("enable instruction ignored");
	return_op_a: assert property (@(posedge clk) disable iff (srst) // RULE_12
		ce && ops.irq_return_op && !any_rst && !ops.global_irq_off_op && !vt_d |=> gie_q)
		else $error("return did not enable");
	reset_clears_a: assert property (@(posedge clk) disable iff (srst) // RULE_19
		ce && any_rst |=> flag_q == 3'h0 && mask_q == 3'h0)
		else $error("reset left flags");
	wdc_reset_a: assert property (@(posedge clk) disable iff (srst) // RULE_20
		ce && any_rst |=> wdc_q[7] && !wdc_q[6] && !wdc_q[4])
		else $error("watchdog control reset wrong");
	power_on_tp_a: assert property (@(posedge clk) disable iff (srst) // RULE_17
		ce && power_on |=> t_q && p_q)
		else $error("power-on status wrong");
	sleep_tp_a: assert property (@(posedge clk) disable iff (srst) // RULE_18
		ce && ops.sleep_op && !any_rst && mode_q == irs_pkg::IRS_RUN |=> t_q && !p_q && sleeping)
		else $error("sleep status wrong");
	wdt_timeout_a: assert property (@(posedge clk) disable iff (srst) // RULE_16
		ce && wdt_timeout && !power_on |=> !t_q)
		else $error("time-out flag kept");
	// Reset and wake status, then masked request vectoring
	pin_keep_a: assert property (@(posedge clk) disable iff (srst) // RULE_15
		ce && pin_rise && !power_on && !wdt_timeout && mode_q == irs_pkg::IRS_RUN
		|=> t_q == $past(t_q) && p_q == $past(p_q))
		else $error("pin reset changed status");
	pin_wake_a: assert property (@(posedge clk) disable iff (srst) // RULE_15
		ce && pin_rise && !power_on && !wdt_timeout && mode_q == irs_pkg::IRS_SLEEP
		|=> t_q && !p_q && !sleeping)
		else $error("pin wake status wrong");
	wdt_sleep_a: assert property (@(posedge clk) disable iff (srst) // RULE_16
		ce && wdt_timeout && !power_on && mode_q == irs_pkg::IRS_SLEEP |=> !t_q && !p_q)
		else $error("watchdog wake status wrong");
	wake_vector_a: assert property (@(posedge clk) disable iff (srst) // RULE_04
		ce && sleeping && port_chg && mask_q[`IRS_BIT_PORT] && gie_q && !any_rst
		|=> wake && vec_take && vec_addr == `IRS_VEC_IRQ)
		else $error("port wake did not vector");
	irq_request_a: assert property (@(posedge clk) disable iff (srst) // RULE_11
		ce && !sleeping && (stat_rd & mask_rd) != 8'h00 && gie_q && !vt_q && !any_rst
		&& !ops.sleep_op && !ops.trap_op |=> vec_take && vec_addr == `IRS_VEC_IRQ)
		else $error("masked request not taken");
	cov_irq_c: cover property (@(posedge clk) vt_q && va_q == `IRS_VEC_IRQ);
	cov_wdt_sleep_c: cover property (@(posedge clk) ce && wdt_timeout && sleeping);
	cov_pin_sleep_c: cover property (@(posedge clk) ce && pin_rise && sleeping);
	cov_wake_c: cover property (@(posedge clk) wake_q);
	cov_trap_c: cover property (@(posedge clk) vt_q && va_q == `IRS_VEC_TRAP);
endmodule
`default_nettype wire

// ===== test/irs_cpu_mdl.sv
// Core model that services a vector: clears the flags, then returns
`timescale 1ns/10ps
`default_nettype none
module irs_cpu_mdl (
	input wire logic clk,
	input wire logic vec_take,
	output var irs_pkg::irs_acc_s acc,
	output var irs_pkg::irs_ops_s ops
);
	logic [1:0] st; // Service step
	// Acts just after each edge, so the block samples settled values
	initial begin
		acc = '0;
		ops = '0;
		st = 2'h0;
		forever begin
			@(posedge clk);
			#1;
			if (vec_take) st = 2'h1;
			else if (st == 2'h1) st = 2'h2;
			else st = 2'h0;
			acc = (st == 2'h1) ? {1'b1, 1'b0, 8'h0f, 8'h00} : '0;
			ops = '0;
			ops.irq_return_op = (st == 2'h2);
		end
	end
endmodule
`default_nettype wire

// ===== test/irq_and_reset_status_tb_top.sv
// Testbench of the interrupt and reset status block
`timescale 1ns/10ps
`default_nettype none
module irq_and_reset_status_tb_top;
	logic clk, srst, power_on, rst_pin_n, wdt_timeout, tovf, ext_pin, port_read;
	logic [7:0] port_in, stat_rd, mask_rd, wdc_rd;
	logic [17:0] acc_t; // Bench side of register access
	logic [5:0] ops_t; // Bench side of instruction strobes
	irs_pkg::irs_acc_s acc_m, acc;
	irs_pkg::irs_ops_s ops_m, ops;
	logic tf, pf, gie, slp, rso, wake, vt;
	logic [10:0] va, lastv;
	int n_mismatch = 0, n_compared = 0, nv = 0, nw = 0;
	// Bench and core model drives are ORed, so both can act in one cycle
	assign acc = irs_pkg::irs_acc_s'(acc_t | acc_m);
	assign ops = irs_pkg::irs_ops_s'(ops_t | ops_m);
	irs_core irs_core_i (.clk(clk), .srst(srst), .ce(1'b1), .power_on(power_on),
		.rst_pin_n(rst_pin_n), .wdt_timeout(wdt_timeout), .timer_counter_ovf(tovf),
		.ext_pin(ext_pin), .port_in(port_in), .port_is_out(8'h20), .port_read(port_read),
		.ops(ops), .acc(acc), .stat_rd(stat_rd), .mask_rd(mask_rd), .wdc_rd(wdc_rd),
		.time_out_flag(tf), .power_down_flag(pf), .global_irq_en(gie), .sleeping(slp),
		.reset_out(rso), .wake(wake), .vec_take(vt), .vec_addr(va));
	irs_cpu_mdl irs_cpu_mdl_i (.clk(clk), .vec_take(vt), .acc(acc_m), .ops(ops_m));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Pulses are counted mid-cycle, where they are settled
	always @(negedge clk) begin
		if (vt === 1'b1) begin
			nv++;
			lastv = va;
		end
		if (wake === 1'b1) nw++;
	end
	task automatic tk(input int n);
		repeat (n) begin
			@(posedge clk);
			#1;
		end
	endtask
	// Control space when c is high, data space otherwise
	task automatic wr(input logic c, input logic [7:0] a, input logic [7:0] d);
		acc_t = {~c, c, a, d};
		tk(1);
		acc_t = '0;
	endtask
	task automatic op(input logic [5:0] v);
		ops_t = v;
		tk(1);
		ops_t = '0;
	endtask
	task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
		n_compared++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			n_mismatch++;
		end
	endtask
	task automatic end_of_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		srst = 1'b1;
		{power_on, wdt_timeout, port_read} = 3'h0;
		{rst_pin_n, tovf, ext_pin} = 3'h7;
		port_in = 8'h00;
		acc_t = '0;
		ops_t = '0;
		lastv = '0;
		tk(20);
		srst = 1'b0;
		tk(1);
		chk("stat", stat_rd, 11'h000);
		chk("mask", mask_rd, 11'h000);
		chk("wdc", wdc_rd, 11'h080);
		chk("tp", {tf, pf}, 11'h003);
		// Unmasked events set flags but never vector
		op(6'h20);
		wr(1'b1, 8'h0e, 8'hc0);
		{tovf, ext_pin} = 2'h0;
		tk(4);
		chk("stat", stat_rd, 11'h005);
		chk("gie", gie, 11'h001);
		chk("nvec", nv[10:0], 11'h000);
		{tovf, ext_pin} = 2'h3;
		wr(1'b0, 8'h0f, 8'h00);
		tk(1);
		wr(1'b1, 8'h0f, 8'h01);
		tk(2);
		chk("mask", mask_rd, 11'h001);
		tovf = 1'b0;
		tk(4);
		chk("nvec", nv[10:0], 11'h001);
		chk("vec", lastv, 11'h008);
		tk(3);
		chk("gie", gie, 11'h001);
		op(6'h01);
		tk(4);
		chk("vec", lastv, 11'h001);
		op(6'h10);
		tk(1);
		chk("gie", gie, 11'h000);
		tovf = 1'b1;
		// Port wake from sleep with global enable off
		wr(1'b1, 8'h0f, 8'h02);
		port_read = 1'b1;
		tk(1);
		port_read = 1'b0;
		op(6'h04);
		tk(2);
		chk("sleep", {slp, tf, pf}, 11'h006);
		port_in = 8'h20;
		tk(3);
		chk("nwake", nw[10:0], 11'h000);
		port_in = 8'h28;
		tk(4);
		chk("nwake", nw[10:0], 11'h001);
		chk("stat", stat_rd, 11'h002);
		chk("wake", {slp, tf, pf, nv[1:0]}, 11'h00a);
		wr(1'b0, 8'h0f, 8'h00);
		op(6'h02);
		tk(2);
		chk("tp", {tf, pf}, 11'h003);
		wdt_timeout = 1'b1;
		tk(1);
		wdt_timeout = 1'b0;
		tk(3);
		chk("tp", {tf, pf}, 11'h001);
		chk("mask", mask_rd, 11'h000);
		chk("wdc", wdc_rd, 11'h080);
		wr(1'b1, 8'h0f, 8'h07);
		rst_pin_n = 1'b0;
		tk(3);
		chk("rst", rso, 11'h001);
		rst_pin_n = 1'b1;
		tk(3);
		chk("rst", {rso, tf, pf}, 11'h001);
		chk("mask", mask_rd, 11'h000);
		power_on = 1'b1;
		tk(1);
		power_on = 1'b0;
		tk(3);
		chk("tp", {tf, pf}, 11'h003);
		// Port wake with global enable on enters the handler at once
		port_read = 1'b1;
		tk(1);
		port_read = 1'b0;
		wr(1'b1, 8'h0f, 8'h02);
		op(6'h20);
		tk(1);
		op(6'h04);
		port_in = 8'h2c;
		tk(2);
		chk("nvec", nv[10:0], 11'h003);
		chk("vec", lastv, 11'h008);
		chk("wake", {slp, tf, pf, nw[1:0]}, 11'h00a);
		// Disable beside the model's return, then refresh the snapshot
		op(6'h10);
		port_read = 1'b1;
		tk(1);
		port_read = 1'b0;
		wr(1'b0, 8'h0f, 8'h00);
		tk(3);
		chk("nvec", nv[10:0], 11'h003);
		chk("stat", stat_rd, 11'h000);
		// Reset pin, then watchdog, while asleep
		op(6'h04);
		rst_pin_n = 1'b0;
		tk(2);
		rst_pin_n = 1'b1;
		tk(2);
		chk("pin", {slp, tf, pf}, 11'h002);
		op(6'h02);
		tk(1);
		op(6'h04);
		wdt_timeout = 1'b1;
		tk(1);
		wdt_timeout = 1'b0;
		tk(2);
		chk("wdt", {slp, tf, pf}, 11'h000);
		end_of_test();
	end
endmodule
`default_nettype wire
